/* hw/serial_bridge.sv */
// Board-side serial bridge with handshake modes and two host paths
// Contract
// - Reset: 115200 8N1, handshake ignored
// - Baud selectable from 9600 to 921600
// - Each handshake line switched independently
// - Deassert target CTS when buffer full
// - Stop sending while target RTS deasserted
// - Finish character already being shifted out
// - Without inbound handshake, ignore RTS level; code ignores RTS in disabled and rts modes, watches it in cts
// - Drive CTS only in rts, rtscts
// - Watch RTS only in cts, rtscts
// - Four modes: disabled, rts, cts, rtscts
// - Relay bytes both ways to active path
// - Socket path wins; USB then idle
// - Link: txd, rxd, RTS, CTS, enable
//
// The implementer's own choices: the register addresses and register access over APB.
module serial_bridge #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tgt_txd,
  output logic             tgt_rxd,
  input  wire logic        tgt_rts_n,
  output logic             tgt_cts_n_o,
  output logic             tgt_cts_n_oe,
  input  wire logic        vcom_enable,
  input  wire logic        sock_connected,
  input  wire logic        usb_in_valid,
  input  wire logic [7:0]  usb_in_data,
  output logic             usb_in_ready,
  input  wire logic        sock_in_valid,
  input  wire logic [7:0]  sock_in_data,
  output logic             sock_in_ready,
  output logic             usb_out_valid,
  output logic [7:0]       usb_out_data,
  input  wire logic        usb_out_ready,
  output logic             sock_out_valid,
  output logic [7:0]       sock_out_data,
  input  wire logic        sock_out_ready
);
  bridge_pkg::cfg_s       cfg_ff;
  bridge_pkg::ser_state_e rx_state_ff;
  bridge_pkg::ser_state_e tx_state_ff;
  bridge_pkg::byte_s      hold_ff;
  bridge_pkg::byte_s      nxt_hold;
  logic          rxd_meta_ff;
  logic          rxd_sync_ff;
  logic          rts_meta_ff;
  logic          rts_sync_ff;
  logic          en_meta_ff;
  logic          en_sync_ff;
  logic [15:0]   rx_cnt_ff;
  logic [2:0]    rx_bit_ff;
  logic [7:0]    rx_shift_ff;
  logic [15:0]   tx_cnt_ff;
  logic [2:0]    tx_bit_ff;
  logic [7:0]    tx_shift_ff;
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          rd_pend_ff;
  logic          rd_sock_ff;
  logic          overrun_ff;
  logic [7:0]    ram_q;
  logic          apb_done;
  logic          apb_write;
  logic          addr_hit;
  logic          rx_push;
  logic          fifo_full;
  logic          out_busy;
  logic          out_take;
  logic          rd_issue;
  logic          host_accept;
  logic          tx_gate_open;
  logic          tx_launch;
  logic          rx_bit_end;
  logic          tx_bit_end;
  // APB access completes in the cycle pready is high
  assign apb_done  = psel && penable && pready;
  assign apb_write = apb_done && pwrite;
  assign addr_hit  = (paddr == bridge_pkg::MODE_OFFSET) || (paddr == bridge_pkg::DIV_OFFSET)
                     || (paddr == bridge_pkg::STATUS_OFFSET);
  // One wait state per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_hit;
    end
  end
  // Read data captured as pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      prdata <= '0;
      unique case (paddr)
        bridge_pkg::MODE_OFFSET: prdata[1:0] <= cfg_ff.mode;
        bridge_pkg::DIV_OFFSET: prdata[15:0] <= cfg_ff.divisor;
        bridge_pkg::STATUS_OFFSET: begin
          prdata[bridge_pkg::STAT_LEVEL_LSB +: AW+1] <= count_ff;
          prdata[bridge_pkg::STAT_TX_BUSY_BIT]       <= (tx_state_ff != bridge_pkg::SER_IDLE);
          prdata[bridge_pkg::STAT_RTS_BIT]           <= !rts_sync_ff;
          prdata[bridge_pkg::STAT_SOCK_BIT]          <= sock_connected;
          prdata[bridge_pkg::STAT_FULL_BIT]          <= fifo_full;
          prdata[bridge_pkg::STAT_OVERRUN_BIT]       <= overrun_ff;
        end
        default: prdata <= '0;
      endcase
    end
  end
  // Configuration; reset gives 115200 baud and handshake off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= bridge_pkg::CFG_RESET;
    end else if (apb_write && paddr == bridge_pkg::MODE_OFFSET) begin
      cfg_ff.mode <= bridge_pkg::hs_mode_e'(pwdata[1:0]);
    end else if (apb_write && paddr == bridge_pkg::DIV_OFFSET) begin
      cfg_ff.divisor <= bridge_pkg::clamp_div(pwdata);
    end
  end
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
      rts_meta_ff <= 1'b1;
      rts_sync_ff <= 1'b1;
      en_meta_ff  <= 1'b0;
      en_sync_ff  <= 1'b0;
    end else begin
      rxd_meta_ff <= tgt_txd;
      rxd_sync_ff <= rxd_meta_ff;
      rts_meta_ff <= tgt_rts_n;
      rts_sync_ff <= rts_meta_ff;
      en_meta_ff  <= vcom_enable;
      en_sync_ff  <= en_meta_ff;
    end
  end
  // Receiver from target, 8N1, sampled mid-bit
  assign rx_bit_end = (rx_cnt_ff == '0);
  assign fifo_full  = (count_ff == (AW+1)'(DEPTH));
  assign rx_push    = (rx_state_ff == bridge_pkg::SER_STOP) && rx_bit_end && rxd_sync_ff
                      && !fifo_full;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_ff <= bridge_pkg::SER_IDLE;
      rx_cnt_ff   <= '0;
      rx_bit_ff   <= '0;
      rx_shift_ff <= '0;
    end else begin
      unique case (rx_state_ff)
        bridge_pkg::SER_IDLE: begin
          if (en_sync_ff && !rxd_sync_ff) begin
            rx_state_ff <= bridge_pkg::SER_START;
            rx_cnt_ff   <= cfg_ff.divisor >> 1;
          end
        end
        bridge_pkg::SER_START: begin
          if (!rx_bit_end) begin
            rx_cnt_ff <= rx_cnt_ff - 16'h0001;
          end else if (rxd_sync_ff) begin
            rx_state_ff <= bridge_pkg::SER_IDLE;
          end else begin
            rx_state_ff <= bridge_pkg::SER_DATA;
            rx_cnt_ff   <= cfg_ff.divisor - 16'h0001;
            rx_bit_ff   <= '0;
          end
        end
        bridge_pkg::SER_DATA: begin
          if (!rx_bit_end) begin
            rx_cnt_ff <= rx_cnt_ff - 16'h0001;
          end else begin
            rx_shift_ff <= {rxd_sync_ff, rx_shift_ff[7:1]};
            rx_cnt_ff   <= cfg_ff.divisor - 16'h0001;
            rx_bit_ff   <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == bridge_pkg::LAST_DATA_BIT) begin
              rx_state_ff <= bridge_pkg::SER_STOP;
            end
          end
        end
        bridge_pkg::SER_STOP: begin
          if (!rx_bit_end) begin
            rx_cnt_ff <= rx_cnt_ff - 16'h0001;
          end else begin
            rx_state_ff <= bridge_pkg::SER_IDLE;
          end
        end
        default: rx_state_ff <= bridge_pkg::SER_IDLE;
      endcase
    end
  end
  // Overrun sticky; new event wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_ff <= 1'b0;
    end else if ((rx_state_ff == bridge_pkg::SER_STOP) && rx_bit_end && rxd_sync_ff
                 && fifo_full) begin
      overrun_ff <= 1'b1;
    end else if (apb_write && paddr == bridge_pkg::STATUS_OFFSET
                 && pwdata[bridge_pkg::STAT_OVERRUN_BIT]) begin
      overrun_ff <= 1'b0;
    end
  end
  // Receive buffer toward the host
  assign out_busy = usb_out_valid || sock_out_valid || rd_pend_ff;
  assign out_take = (usb_out_valid && usb_out_ready) || (sock_out_valid && sock_out_ready);
  assign rd_issue = (count_ff != '0) && !rd_pend_ff && (!out_busy || out_take);
  bridge_ram #(.WIDTH (8), .DEPTH (DEPTH), .AW (AW)) i_bridge_ram (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (rx_push),
    .waddr (wr_ptr_ff),
    .wdata (rx_shift_ff),
    .raddr (rd_ptr_ff),
    .rdata (ram_q)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(rx_push);
      rd_ptr_ff <= rd_ptr_ff + AW'(rd_issue);
      count_ff <= count_ff + (AW+1)'(rx_push) - (AW+1)'(rd_issue);
    end
  end
  // Output byte goes to the socket when connected, else USB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pend_ff     <= 1'b0;
      rd_sock_ff     <= 1'b0;
      usb_out_valid  <= 1'b0;
      sock_out_valid <= 1'b0;
      usb_out_data   <= '0;
      sock_out_data  <= '0;
    end else begin
      rd_pend_ff <= rd_issue;
      rd_sock_ff <= rd_issue ? sock_connected : rd_sock_ff;
      if (usb_out_valid && usb_out_ready) begin
        usb_out_valid <= 1'b0;
      end
      if (sock_out_valid && sock_out_ready) begin
        sock_out_valid <= 1'b0;
      end
      if (rd_pend_ff && rd_sock_ff) begin
        sock_out_valid <= 1'b1;
        sock_out_data  <= ram_q;
      end else if (rd_pend_ff) begin
        usb_out_valid <= 1'b1;
        usb_out_data  <= ram_q;
      end
    end
  end
  // Target CTS: driven only in rts and rtscts, deasserted when full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_cts_n_oe <= 1'b0;
      tgt_cts_n_o  <= 1'b1;
    end else begin
      tgt_cts_n_oe <= cfg_ff.mode[bridge_pkg::MODE_CTS_DRIVE_BIT];
      tgt_cts_n_o  <= fifo_full || !cfg_ff.mode[bridge_pkg::MODE_CTS_DRIVE_BIT];
    end
  end
  // Host to target holding byte; only the active path is accepted
  assign host_accept = sock_connected ? (sock_in_valid && sock_in_ready)
                                      : (usb_in_valid && usb_in_ready);
  assign tx_gate_open = !cfg_ff.mode[bridge_pkg::MODE_RTS_WATCH_BIT]
                        || !rts_sync_ff;
  assign tx_launch    = (tx_state_ff == bridge_pkg::SER_IDLE) && hold_ff.valid && en_sync_ff
                        && tx_gate_open;
  always_comb begin
    nxt_hold = hold_ff;
    if (tx_launch) begin
      nxt_hold.valid = 1'b0;
    end
    if (host_accept) begin
      nxt_hold.valid = 1'b1;
      nxt_hold.data  = sock_connected ? sock_in_data : usb_in_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff       <= '0;
      usb_in_ready  <= 1'b0;
      sock_in_ready <= 1'b0;
    end else begin
      hold_ff       <= nxt_hold;
      usb_in_ready  <= !nxt_hold.valid && !sock_connected;
      sock_in_ready <= !nxt_hold.valid && sock_connected;
    end
  end
  // Transmitter toward target; a started frame always completes
  assign tx_bit_end = (tx_cnt_ff == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_ff <= bridge_pkg::SER_IDLE;
      tx_cnt_ff   <= '0;
      tx_bit_ff   <= '0;
      tx_shift_ff <= '0;
      tgt_rxd     <= 1'b1;
    end else begin
      unique case (tx_state_ff)
        bridge_pkg::SER_IDLE: begin
          tgt_rxd <= 1'b1;
          if (tx_launch) begin
            tx_state_ff <= bridge_pkg::SER_START;
            tx_shift_ff <= hold_ff.data;
            tx_cnt_ff   <= cfg_ff.divisor - 16'h0001;
            tgt_rxd     <= 1'b0;
          end
        end
        bridge_pkg::SER_START: begin
          if (!tx_bit_end) begin
            tx_cnt_ff <= tx_cnt_ff - 16'h0001;
          end else begin
            tx_state_ff <= bridge_pkg::SER_DATA;
            tx_cnt_ff   <= cfg_ff.divisor - 16'h0001;
            tx_bit_ff   <= '0;
            tgt_rxd     <= tx_shift_ff[0];
            tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
          end
        end
        bridge_pkg::SER_DATA: begin
          if (!tx_bit_end) begin
            tx_cnt_ff <= tx_cnt_ff - 16'h0001;
          end else begin
            tx_cnt_ff <= cfg_ff.divisor - 16'h0001;
            tx_bit_ff <= tx_bit_ff + 3'h1;
            if (tx_bit_ff == bridge_pkg::LAST_DATA_BIT) begin
              tx_state_ff <= bridge_pkg::SER_STOP;
              tgt_rxd     <= 1'b1;
            end else begin
              tgt_rxd     <= tx_shift_ff[0];
              tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
            end
          end
        end
        bridge_pkg::SER_STOP: begin
          if (!tx_bit_end) begin
            tx_cnt_ff <= tx_cnt_ff - 16'h0001;
          end else begin
            tx_state_ff <= bridge_pkg::SER_IDLE;
          end
        end
        default: tx_state_ff <= bridge_pkg::SER_IDLE;
      endcase
    end
  end

endmodule : serial_bridge

/* hw/bridge_pkg.sv */
// Constants, modes and carriers shared by the serial bridge files
package bridge_pkg;

  localparam int unsigned CLK_HZ     = 125_000_000;
  localparam int unsigned BAUD_RESET = 115_200;
  localparam int unsigned BAUD_MIN   = 9_600;
  localparam int unsigned BAUD_MAX   = 921_600;

  // Clock cycles per bit; fastest rate rounds up, slowest rounds down
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / BAUD_RESET);
  localparam logic [15:0] DIV_MIN   = 16'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
  localparam logic [15:0] DIV_MAX   = 16'(CLK_HZ / BAUD_MIN);

  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  // Register byte offsets
  localparam logic [11:0] MODE_OFFSET   = 12'h000;
  localparam logic [11:0] DIV_OFFSET    = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // Mode register bits
  localparam int unsigned MODE_CTS_DRIVE_BIT = 0;
  localparam int unsigned MODE_RTS_WATCH_BIT = 1;

  // Status register fields
  localparam int unsigned STAT_LEVEL_LSB   = 0;
  localparam int unsigned STAT_TX_BUSY_BIT = 16;
  localparam int unsigned STAT_RTS_BIT     = 17;
  localparam int unsigned STAT_SOCK_BIT    = 18;
  localparam int unsigned STAT_FULL_BIT    = 19;
  localparam int unsigned STAT_OVERRUN_BIT = 20;

  typedef enum logic [1:0] {
    HS_DISABLED = 2'h0,
    HS_RTS      = 2'h1,
    HS_CTS      = 2'h2,
    HS_RTSCTS   = 2'h3
  } hs_mode_e;

  typedef enum logic [3:0] {
    SER_IDLE  = 4'b0001,
    SER_START = 4'b0010,
    SER_DATA  = 4'b0100,
    SER_STOP  = 4'b1000
  } ser_state_e;

  typedef struct packed {
    hs_mode_e    mode;
    logic [15:0] divisor;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{mode: HS_DISABLED, divisor: DIV_RESET};

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_s;

  function automatic logic [15:0] clamp_div(input logic [31:0] value);
    logic [15:0] result;
    result = DIV_RESET;
    if (value < 32'(DIV_MIN)) begin
      result = DIV_MIN;
    end else if (value > 32'(DIV_MAX)) begin
      result = DIV_MAX;
    end else begin
      result = value[15:0];
    end
    return result;
  endfunction : clamp_div

endpackage : bridge_pkg

/* hw/bridge_ram.sv */
// Receive buffer storage with registered read data
module bridge_ram #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : bridge_ram

/* tb/target_uart.sv */
// Target-side UART model: 8N1, paced by clear-to-send, drives request-to-send
module target_uart (
  input  wire logic        clk,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  input  wire logic [15:0] div,
  input  wire logic        hold_rts,
  input  wire logic [7:0]  tx_limit,
  output logic             txd,
  output logic             rts_n,
  output logic [7:0]       rx_byte,
  output logic [7:0]       rx_count,
  output logic [7:0]       tx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] sh;
  logic [7:0] rs;
  int         i;
  int         j;
  assign rts_n = hold_rts;
  initial begin
    txd = 1'b1;
    tx_count = 8'h00;
    forever begin
      @(posedge clk);
      if (tx_count != tx_limit && cts_n === 1'b0) begin
        sh = {1'b1, 8'hA0 + tx_count, 1'b0};
        for (i = 0; i < 10; i++) begin
          txd <= sh[i];
          repeat (div) @(posedge clk);
        end
        tx_count <= tx_count + 8'h01;
      end
    end
  end
  initial begin
    rx_count = 8'h00;
    forever begin
      @(negedge rxd);
      repeat (div + div / 2) @(posedge clk);
      for (j = 0; j < 8; j++) begin
        rs[j] = rxd;
        repeat (div) @(posedge clk);
      end
      rx_byte = rs;
      rx_count = rx_count + 8'h01;
    end
  end
endmodule : target_uart

/* tb/serial_bridge_chk.sv */
// Port checker for the serial bridge
module serial_bridge_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tgt_rxd,
  input wire logic        tgt_cts_n_oe,
  input wire logic        sock_connected,
  input wire logic        usb_in_valid,
  input wire logic        usb_in_ready,
  input wire logic        sock_in_valid,
  input wire logic        sock_in_ready,
  input wire logic        usb_out_valid,
  input wire logic [7:0]  usb_out_data,
  input wire logic        usb_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode_wr;
  assign mode_wr = psel && penable && pready && pwrite && paddr == bridge_pkg::MODE_OFFSET;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence low_bit_s; !tgt_rxd [*8]; endsequence
  sequence high_bit_s; tgt_rxd [*8]; endsequence
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rxd_low_bit_a: assert property ($fell(tgt_rxd) |-> low_bit_s)
    else $error("low bit too short");
  rxd_high_bit_a: assert property ($rose(tgt_rxd) |-> high_bit_s)
    else $error("high bit too short");
  cts_oe_mode_a: assert property ($changed(tgt_cts_n_oe) |->
    $past(mode_wr) || $past(mode_wr, 2)) else $error("cts enable moved without mode write");
  usb_unsel_a: assert property (sock_connected && $past(sock_connected) |-> !usb_in_ready)
    else $error("usb ready while socket selected");
  usb_take_a: assert property (usb_in_valid && usb_in_ready |=> !usb_in_ready)
    else $error("usb ready not dropped after take");
  sock_take_a: assert property (sock_in_valid && sock_in_ready |=> !sock_in_ready)
    else $error("socket ready not dropped after take");
  usb_hold_a: assert property (usb_out_valid && !usb_out_ready |=>
    usb_out_valid && $stable(usb_out_data)) else $error("usb out byte not held");
endmodule : serial_bridge_chk

bind serial_bridge serial_bridge_chk i_serial_bridge_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .tgt_rxd(tgt_rxd),
  .tgt_cts_n_oe(tgt_cts_n_oe), .sock_connected(sock_connected),
  .usb_in_valid(usb_in_valid), .usb_in_ready(usb_in_ready), .sock_in_valid(sock_in_valid),
  .sock_in_ready(sock_in_ready), .usb_out_valid(usb_out_valid),
  .usb_out_data(usb_out_data), .usb_out_ready(usb_out_ready)
);

/* tb/serial_bridge_bench.sv */
// Testbench for the serial bridge with a target UART model
module serial_bridge_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME = 1360;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        tgt_txd, tgt_rxd, tgt_rts_n, tgt_cts_n_o, tgt_cts_n_oe, cts_line;
  logic        vcom_enable, sock_connected, hold_rts;
  logic        usb_in_valid, usb_in_ready, sock_in_valid, sock_in_ready;
  logic        usb_out_valid, usb_out_ready, sock_out_valid, sock_out_ready;
  logic [7:0]  usb_in_data, sock_in_data, usb_out_data, sock_out_data;
  logic [7:0]  rx_byte, rx_count, tx_count, tx_limit;
  logic [7:0]  usb_got, sock_got;
  logic [7:0]  usb_n = 8'h00;
  logic [7:0]  sock_n = 8'h00;
  logic [15:0] div;
  logic        e;
  int          errors, n_checks;
  // Undriven clear-to-send reads as asserted through a pull-down
  assign cts_line = tgt_cts_n_oe ? tgt_cts_n_o : 1'b0;
  serial_bridge i_serial_bridge (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tgt_txd(tgt_txd), .tgt_rxd(tgt_rxd),
    .tgt_rts_n(tgt_rts_n), .tgt_cts_n_o(tgt_cts_n_o), .tgt_cts_n_oe(tgt_cts_n_oe),
    .vcom_enable(vcom_enable), .sock_connected(sock_connected),
    .usb_in_valid(usb_in_valid), .usb_in_data(usb_in_data), .usb_in_ready(usb_in_ready),
    .sock_in_valid(sock_in_valid), .sock_in_data(sock_in_data),
    .sock_in_ready(sock_in_ready), .usb_out_valid(usb_out_valid),
    .usb_out_data(usb_out_data), .usb_out_ready(usb_out_ready),
    .sock_out_valid(sock_out_valid), .sock_out_data(sock_out_data),
    .sock_out_ready(sock_out_ready));
  target_uart i_target_uart (.clk(pclk), .rxd(tgt_rxd), .cts_n(cts_line), .div(div),
    .hold_rts(hold_rts), .tx_limit(tx_limit), .txd(tgt_txd), .rts_n(tgt_rts_n),
    .rx_byte(rx_byte), .rx_count(rx_count), .tx_count(tx_count));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (usb_out_valid === 1'b1 && usb_out_ready === 1'b1) begin
      usb_got <= usb_out_data;
      usb_n   <= usb_n + 8'h01;
    end
    if (sock_out_valid === 1'b1 && sock_out_ready === 1'b1) begin
      sock_got <= sock_out_data;
      sock_n   <= sock_n + 8'h01;
    end
  end
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic test_done();
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic host_send(input logic s, input logic [7:0] b);
    int k;
    @(posedge pclk);
    usb_in_data   <= b;
    sock_in_data  <= b;
    usb_in_valid  <= !s;
    sock_in_valid <= s;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((s ? sock_in_ready : usb_in_ready) !== 1'b1 && k < 20000);
    usb_in_valid  <= 1'b0;
    sock_in_valid <= 1'b0;
  endtask : host_send
  task automatic wait_rx(input logic [7:0] n);
    for (int k = 0; k < 20000 && rx_count != n; k++) @(posedge pclk);
  endtask : wait_rx
  task automatic t_reset();
    apb(1'b0, bridge_pkg::MODE_OFFSET, 32'h0);
    check("mode_reset", 32'h0, q);
    apb(1'b0, bridge_pkg::DIV_OFFSET, 32'h0);
    check("div_reset", 32'(bridge_pkg::DIV_RESET), q);
    check("cts_undriven", 32'h0, 32'(tgt_cts_n_oe));
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped_err", 32'h1, 32'(e));
  endtask : t_reset
  task automatic t_usb();
    logic [7:0] n;
    logic [7:0] x;
    n = rx_count;
    host_send(1'b0, 8'h5A);
    wait_rx(n + 8'h01);
    check("usb_to_target", 32'h5A, 32'(rx_byte));
    n = usb_n;
    x = 8'hA0 + tx_count;
    tx_limit <= tx_count + 8'h01;
    for (int k = 0; k < 20000 && usb_n == n; k++) @(posedge pclk);
    check("target_to_usb", 32'(x), 32'(usb_got));
  endtask : t_usb
  task automatic t_baud();
    apb(1'b1, bridge_pkg::DIV_OFFSET, 32'h1);
    apb(1'b0, bridge_pkg::DIV_OFFSET, 32'h0);
    check("div_floor", 32'(bridge_pkg::DIV_MIN), q);
    apb(1'b1, bridge_pkg::DIV_OFFSET, 32'h0000FFFF);
    apb(1'b0, bridge_pkg::DIV_OFFSET, 32'h0);
    check("div_ceiling", 32'(bridge_pkg::DIV_MAX), q);
    apb(1'b1, bridge_pkg::DIV_OFFSET, 32'(bridge_pkg::DIV_MIN));
    div <= bridge_pkg::DIV_MIN;
  endtask : t_baud
  task automatic t_sock();
    logic [7:0] n;
    logic [7:0] x;
    sock_connected <= 1'b1;
    n = rx_count;
    host_send(1'b1, 8'h3C);
    wait_rx(n + 8'h01);
    check("sock_to_target", 32'h3C, 32'(rx_byte));
    check("usb_ready_off", 32'h0, 32'(usb_in_ready));
    n = usb_n;
    x = 8'hA0 + tx_count;
    tx_limit <= tx_count + 8'h01;
    for (int k = 0; k < 5000 && sock_n == 8'h00; k++) @(posedge pclk);
    check("target_to_sock", 32'(x), 32'(sock_got));
    check("usb_out_quiet", 32'(n), 32'(usb_n));
    sock_connected <= 1'b0;
  endtask : t_sock
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, bridge_pkg::MODE_OFFSET, 32'(m));
      repeat (3) @(posedge pclk);
      check("cts_drive_mode", 32'(m % 2), 32'(tgt_cts_n_oe));
    end
  endtask : t_modes
  task automatic t_rts();
    logic [7:0] n;
    hold_rts <= 1'b1;
    apb(1'b1, bridge_pkg::MODE_OFFSET, 32'h2);
    n = rx_count;
    host_send(1'b0, 8'h11);
    repeat (3 * FRAME) @(posedge pclk);
    check("rts_holds_tx", 32'(n), 32'(rx_count));
    hold_rts <= 1'b0;
    wait_rx(n + 8'h01);
    check("rts_resumes", 32'h11, 32'(rx_byte));
    host_send(1'b0, 8'h22);
    for (int k = 0; k < 5000 && tgt_rxd !== 1'b0; k++) @(posedge pclk);
    hold_rts <= 1'b1;
    wait_rx(n + 8'h02);
    check("frame_completes", 32'h22, 32'(rx_byte));
    apb(1'b1, bridge_pkg::MODE_OFFSET, 32'h0);
    host_send(1'b0, 8'h33);
    wait_rx(n + 8'h03);
    check("rts_ignored", 32'h33, 32'(rx_byte));
    hold_rts <= 1'b0;
  endtask : t_rts
  task automatic t_full();
    logic [7:0] lim;
    apb(1'b1, bridge_pkg::MODE_OFFSET, 32'h1);
    usb_out_ready <= 1'b0;
    lim = tx_count + 8'd18;
    tx_limit <= lim;
    for (int k = 0; k < 40000 && cts_line !== 1'b1; k++) @(posedge pclk);
    check("cts_at_full", 32'h1, 32'(cts_line));
    apb(1'b0, bridge_pkg::STATUS_OFFSET, 32'h0);
    check("status_full", 32'h1, 32'(q[bridge_pkg::STAT_FULL_BIT]));
    usb_out_ready <= 1'b1;
    for (int k = 0; k < 20000 && tx_count != lim; k++) @(posedge pclk);
    repeat (FRAME) @(posedge pclk);
    check("cts_reopened", 32'h0, 32'(cts_line));
    check("last_byte", 32'(8'hA0 + lim - 8'h01), 32'(usb_got));
  endtask : t_full
  initial begin
    {psel, penable, pwrite, hold_rts, sock_connected} = '0;
    {usb_in_valid, sock_in_valid, usb_in_data, sock_in_data} = '0;
    {paddr, pwdata, tx_limit} = '0;
    {usb_out_ready, sock_out_ready, vcom_enable} = 3'b111;
    div = bridge_pkg::DIV_RESET;
    errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_usb();
    t_baud();
    t_sock();
    t_modes();
    t_rts();
    t_full();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    test_done();
  end
endmodule : serial_bridge_bench
